// file: core/cs_wait_bus.sv
// module: chip select decoder with wait states and bus mode sequencer
`default_nettype none
module cs_wait_bus
  import cs_wait_pkg::*;
#(
  parameter int N = NUM_CS
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // configuration write port
  input  wire logic             cfg_we,
  input  wire logic [1:0]       cfg_sel,
  input  wire logic [7:0]       cfg_control,
  input  wire logic [7:0]       cfg_lower_bound,
  input  wire logic [7:0]       cfg_upper_bound,
  input  wire logic [1:0]       cfg_bus_mode,
  input  wire logic [3:0]       cfg_state_len,
  input  wire logic             cfg_mux_enable,
  // configuration readback of the selected entry
  output logic [7:0]            rd_control,
  output logic [7:0]            rd_lower_bound,
  output logic [7:0]            rd_upper_bound,
  // processor access
  input  wire logic             cpu_req,
  input  wire logic             cpu_is_io,
  input  wire logic             cpu_wr,
  input  wire logic [23:0]      cpu_addr,
  input  wire logic [7:0]       cpu_wdata,
  output logic                  cpu_ready,
  output logic [7:0]            cpu_rdata,
  // external bus pins
  output logic [23:0]           addr_out,
  output logic [7:0]            data_out,
  output logic                  data_oe,
  input  wire logic [7:0]       data_in,
  output logic                  chip_select_out_0_n,
  output logic                  chip_select_out_1_n,
  output logic                  chip_select_out_2_n,
  output logic                  chip_select_out_3_n,
  output logic                  memory_request_n,
  output logic                  io_request_n,
  output logic                  rd_n,
  output logic                  wr_n,
  output logic                  addr_latch,
  input  wire logic             wait_n,
  // bus arbitration with an external master
  input  wire logic             bus_request_in_n,
  output logic                  bus_grant_out_n,
  input  wire logic [23:0]      ext_addr,
  input  wire logic             ext_memory_request_n,
  input  wire logic             ext_io_request_n
);
  // ----------------------------------------
  // configuration store
  // ----------------------------------------
  logic [7:0] select_control_ff [N];
  logic [7:0] lower_bound_ff    [N];
  logic [7:0] upper_bound_ff    [N];
  logic [1:0] bus_mode_ff       [N];
  logic [3:0] state_len_ff      [N];
  logic       mux_enable_ff     [N];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        select_control_ff[i] <= CTL_RST;
        lower_bound_ff[i]    <= LB_RST;
        upper_bound_ff[i]    <= (i == 0) ? UB0_RST : UB_RST;
        bus_mode_ff[i]       <= MODE_RST;
        state_len_ff[i]      <= STATE_LEN_RST;
        mux_enable_ff[i]     <= 1'b0;
      end
    end else if (cfg_we) begin
      select_control_ff[cfg_sel] <= cfg_control;
      lower_bound_ff[cfg_sel]    <= cfg_lower_bound;
      upper_bound_ff[cfg_sel]    <= cfg_upper_bound;
      bus_mode_ff[cfg_sel]       <= cfg_bus_mode;
      // zero length clamped to one cycle
      state_len_ff[cfg_sel]      <= (cfg_state_len == 4'h0) ? 4'h1 : cfg_state_len;
      // stored multiplex option; no bus mode reads it and addr_latch stays low
      mux_enable_ff[cfg_sel]     <= cfg_mux_enable;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_control     <= CTL_RST;
      rd_lower_bound <= LB_RST;
      rd_upper_bound <= UB0_RST;
    end else begin
      rd_control     <= select_control_ff[cfg_sel];
      rd_lower_bound <= lower_bound_ff[cfg_sel];
      rd_upper_bound <= upper_bound_ff[cfg_sel];
    end
  end

  // ----------------------------------------
  // wait input synchroniser
  // ----------------------------------------
  logic wait_s1_ff;
  logic wait_s2_ff;
  logic wait_s3_ff;
  logic wait_low_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_s1_ff  <= 1'b1;
      wait_s2_ff  <= 1'b1;
      wait_s3_ff  <= 1'b1;
      wait_low_ff <= 1'b0;
    end else begin
      wait_s1_ff <= wait_n;
      wait_s2_ff <= wait_s1_ff;
      wait_s3_ff <= wait_s2_ff;
      // level changes only once two stages agree, filtering one-cycle glitches
      if (wait_s2_ff == wait_s3_ff) begin
        wait_low_ff <= ~wait_s2_ff;
      end
    end
  end

  // ----------------------------------------
  // bus arbitration synchroniser and grant
  // ----------------------------------------
  logic breq_s1_ff;
  logic breq_s2_ff;
  logic breq_s3_ff;
  logic breq_ff;
  logic grant_ff;
  logic busy;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      breq_s1_ff <= 1'b1;
      breq_s2_ff <= 1'b1;
      breq_s3_ff <= 1'b1;
      breq_ff    <= 1'b0;
    end else begin
      breq_s1_ff <= bus_request_in_n;
      breq_s2_ff <= breq_s1_ff;
      breq_s3_ff <= breq_s2_ff;
      if (breq_s2_ff == breq_s3_ff) begin
        breq_ff <= ~breq_s2_ff;
      end
    end
  end
  // grant only between cycles; a pending request also blocks new takes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      grant_ff <= 1'b0;
    end else if (!busy) begin
      grant_ff <= breq_ff;
    end
  end
  assign bus_grant_out_n = ~grant_ff;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic [23:0] dec_addr;
  logic        dec_mem;
  logic        dec_io;
  logic        io_internal;
  logic [N-1:0] qualify;
  logic [N-1:0] onehot;
  logic [1:0]  win_idx;
  logic        win_any;
  // external master address keeps being decoded
  assign dec_addr    = grant_ff ? ext_addr : cpu_addr;
  assign dec_mem     = grant_ff ? ~ext_memory_request_n : (cpu_req & ~cpu_is_io);
  assign dec_io      = grant_ff ? ~ext_io_request_n : (cpu_req & cpu_is_io);
  assign io_internal = (dec_addr[15:8] == IO_HI_INT) && (dec_addr[7] == IO_INT_B7);
  always_comb begin
    qualify = '0;
    for (int i = 0; i < N; i++) begin
      if (select_control_ff[i][CTL_EN_BIT]) begin
        if (!select_control_ff[i][CTL_IO_BIT]) begin
          qualify[i] = dec_mem && (lower_bound_ff[i] <= dec_addr[23:16])
                               && (dec_addr[23:16] <= upper_bound_ff[i]);
        end else begin
          qualify[i] = dec_io && !io_internal && (dec_addr[15:8] == lower_bound_ff[i]);
        end
      end
    end
  end
  always_comb begin
    onehot  = '0;
    win_idx = 2'h0;
    win_any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (qualify[i]) begin
        onehot  = '0;
        onehot[i] = 1'b1;
        win_idx = 2'(i);
        win_any = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  bus_state_t  state_ff;
  logic [3:0]  cnt_ff;
  logic [1:0]  idx_ff;
  logic        is_io_ff;
  logic        is_wr_ff;
  logic        legacy;
  logic        take;
  assign legacy = (bus_mode_ff[win_idx] == MODE_LEGACY) && !cpu_wr;
  assign busy   = (state_ff != ST_IDLE);
  assign take   = (state_ff == ST_IDLE) && !grant_ff && !breq_ff && cpu_req && win_any;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
      idx_ff   <= 2'h0;
      is_io_ff <= 1'b0;
      is_wr_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            idx_ff   <= win_idx;
            is_io_ff <= cpu_is_io;
            is_wr_ff <= cpu_wr;
            if (legacy) begin
              state_ff <= ST_T1;
              cnt_ff   <= state_len_ff[win_idx];
            end else begin
              state_ff <= ST_WAITS;
              cnt_ff   <= {1'b0, select_control_ff[win_idx][CTL_WAIT_MSB:CTL_WAIT_LSB]};
            end
          end
        end
        ST_WAITS: begin
          // count down, then hold while wait is low
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (!wait_low_ff) begin
            state_ff <= ST_DONE;
          end
        end
        ST_T1: begin
          if (cnt_ff == 4'h1) begin
            state_ff <= ST_T2;
            cnt_ff   <= state_len_ff[idx_ff];
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_T2: begin
          if (cnt_ff == 4'h1) begin
            // wait seen before end of second state
            state_ff <= wait_low_ff ? ST_TW : ST_T3;
            cnt_ff   <= state_len_ff[idx_ff];
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_TW: begin
          if (!wait_low_ff) begin
            state_ff <= ST_T3;
          end
        end
        ST_T3: begin
          if (cnt_ff == 4'h1) begin
            state_ff <= ST_DONE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_DONE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
  // read data latched at end of final state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= 8'h00;
    end else if (!is_wr_ff && ((state_ff == ST_T3 && cnt_ff == 4'h1) ||
                               (state_ff == ST_WAITS && cnt_ff == 4'h0 && !wait_low_ff))) begin
      cpu_rdata <= data_in;
    end
  end
  assign cpu_ready = (state_ff == ST_DONE);

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  logic       cyc;
  logic       strobe;
  logic [N-1:0] cs_act;
  // select and address from first state, strobes from second in legacy-mode reads and from first in native mode and for legacy-mode writes
  assign cyc    = (state_ff != ST_IDLE) && (state_ff != ST_DONE);
  assign strobe = (state_ff == ST_WAITS) || (state_ff == ST_T2) || (state_ff == ST_TW) || (state_ff == ST_T3);
  // select low only during a qualifying access
  always_comb begin
    cs_act = '0;
    if (grant_ff) begin
      cs_act = onehot;
    end else if (cyc) begin
      cs_act[idx_ff] = 1'b1;
    end
  end
  assign chip_select_out_0_n = ~cs_act[0];
  assign chip_select_out_1_n = ~cs_act[1];
  assign chip_select_out_2_n = ~cs_act[2];
  assign chip_select_out_3_n = ~cs_act[3];
  // native cycles drive strobes for the whole access
  assign memory_request_n = ~(strobe && !is_io_ff);
  assign io_request_n     = ~(strobe && is_io_ff);
  assign rd_n             = ~(strobe && !is_wr_ff);
  assign wr_n             = ~(strobe && is_wr_ff);
  assign addr_latch       = 1'b0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_out <= 24'h000000;
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      if (take) begin
        addr_out <= cpu_addr;
        data_out <= cpu_wdata;
      end
      data_oe <= (state_ff == ST_IDLE) ? (take && cpu_wr) : (cyc && is_wr_ff && state_ff != ST_DONE);
    end
  end
endmodule : cs_wait_bus
`default_nettype wire

// file: core/cs_wait_pkg.sv
// package: constants for the chip select, wait state and bus mode block
`default_nettype none
package cs_wait_pkg;
  localparam int NUM_CS       = 4;
  // ----------------------------------------
  // select control field positions
  // ----------------------------------------
  localparam int CTL_EN_BIT   = 3;
  localparam int CTL_IO_BIT   = 4;
  localparam int CTL_WAIT_LSB = 5;
  localparam int CTL_WAIT_MSB = 7;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CTL_RST       = 8'h00;
  localparam logic [7:0] LB_RST        = 8'h00;
  localparam logic [7:0] UB0_RST       = 8'hff;
  localparam logic [7:0] UB_RST        = 8'h00;
  localparam logic [1:0] MODE_RST      = 2'h0;
  localparam logic [3:0] STATE_LEN_RST = 4'h1;
  // ----------------------------------------
  // bus modes and on-chip peripheral window
  // ----------------------------------------
  localparam logic [1:0] MODE_NATIVE = 2'h0;
  localparam logic [1:0] MODE_LEGACY = 2'h1;
  localparam logic [7:0] IO_HI_INT   = 8'h00;
  localparam logic       IO_INT_B7   = 1'b1;
  typedef enum logic [2:0] {ST_IDLE, ST_WAITS, ST_T1, ST_T2, ST_TW, ST_T3, ST_DONE} bus_state_t;
endpackage : cs_wait_pkg
`default_nettype wire

// file: test/cs_wait_bus_sva.sv
// checker: port properties of the chip select block
`default_nettype none
module cs_wait_bus_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // observed ports
  input wire logic        cpu_req,
  input wire logic        cpu_wr,
  input wire logic        cpu_ready,
  input wire logic [23:0] addr_out,
  input wire logic        chip_select_out_0_n,
  input wire logic        chip_select_out_1_n,
  input wire logic        chip_select_out_2_n,
  input wire logic        chip_select_out_3_n,
  input wire logic        memory_request_n,
  input wire logic        io_request_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        bus_grant_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cs_n;
  assign cs_n = {chip_select_out_3_n, chip_select_out_2_n, chip_select_out_1_n, chip_select_out_0_n};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_pulse;
    cpu_ready ##1 !cpu_ready;
  endsequence
  property p_one_select;
    $countones(~cs_n) <= 1;
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("two selects low");
  property p_idle_high;
    cpu_ready && bus_grant_out_n |-> &cs_n;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("select low at cycle end");
  property p_memory_request_cs;
    bus_grant_out_n && !memory_request_n |-> !(&cs_n) && io_request_n && (rd_n != wr_n);
  endproperty
  a_memory_request_cs: assert property (p_memory_request_cs)
    else $error("memory request without select");
  property p_io_cs;
    bus_grant_out_n && !io_request_n |-> !(&cs_n) && addr_out[15:7] != 9'h001;
  endproperty
  a_io_cs: assert property (p_io_cs)
    else $error("bad io request");
  property p_wr_req;
    bus_grant_out_n && !wr_n |-> cpu_req && cpu_wr;
  endproperty
  a_wr_req: assert property (p_wr_req)
    else $error("write strobe without write");
  property p_rd_req;
    bus_grant_out_n && !rd_n |-> cpu_req && !cpu_wr;
  endproperty
  a_rd_req: assert property (p_rd_req)
    else $error("read strobe without read");
  property p_grant_quiet;
    !bus_grant_out_n |-> !cpu_ready;
  endproperty
  a_grant_quiet: assert property (p_grant_quiet)
    else $error("answer while bus granted");
  property p_ready_pulse;
    cpu_ready |-> s_pulse;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than a cycle");
endmodule : cs_wait_bus_sva
bind cs_wait_bus cs_wait_bus_sva i_sva (.clk, .rstn, .cpu_req, .cpu_wr, .cpu_ready, .addr_out,
  .chip_select_out_0_n, .chip_select_out_1_n, .chip_select_out_2_n, .chip_select_out_3_n,
  .memory_request_n, .io_request_n, .rd_n, .wr_n, .bus_grant_out_n);
`default_nettype wire

// file: test/ext_bus_model.sv
// model: external memory or peripheral answering on the bus
`default_nettype none
module ext_bus_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // bus seen from the device
  input  wire logic [23:0] addr_out,
  input  wire logic        rd_n,
  input  wire logic [3:0]  sel_n,
  input  wire logic [3:0]  stall_len,
  // answer
  output logic [7:0]       data_in,
  output logic             wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff;
  logic       act_ff;
  logic [7:0] last_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 4'h0;
      act_ff <= 1'b0;
    end else begin
      act_ff <= ~&sel_n;
      if (~&sel_n && !act_ff) begin
        cnt_ff <= stall_len;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  assign wait_n = cnt_ff == 4'h0;
  // data only while read strobe low
  // released bus toggles so a late latch shows up
  assign data_in = rd_n ? ~last_ff : addr_out[7:0] ^ 8'h5a;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_ff <= 8'h00;
    end else begin
      last_ff <= data_in;
    end
  end
endmodule : ext_bus_model
`default_nettype wire

// file: test/tb_top.sv
// testbench: chip select, wait state and bus mode block
`default_nettype none
module tb_top;
  import cs_wait_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD_CYCLES = 4000;
  logic        clk = 0, rstn = 0, cfg_we = 0, cfg_mux_enable = 0, cpu_req = 0, cpu_is_io = 0, cpu_wr = 0;
  logic        bus_request_in_n = 1, ext_memory_request_n = 1, ext_io_request_n = 1;
  logic [1:0]  cfg_sel = 0, cfg_bus_mode = 0;
  logic [3:0]  cfg_state_len = 1, stall_len = 0, cs_n;
  logic [7:0]  cfg_control = 0, cfg_lower_bound = 0, cfg_upper_bound = 0, cpu_wdata = 0;
  logic [23:0] cpu_addr = 0, ext_addr = 0, addr_out;
  logic [7:0]  rd_control, rd_lower_bound, rd_upper_bound, cpu_rdata, data_in, data_out;
  logic        cpu_ready, memory_request_n, io_request_n, rd_n, wr_n, wait_n, bus_grant_out_n, data_oe;
  logic        chip_select_out_0_n, chip_select_out_1_n, chip_select_out_2_n, chip_select_out_3_n;
  int          fails = 0, checks_done = 0, lat, base, fc, fr;
  assign cs_n = {chip_select_out_3_n, chip_select_out_2_n, chip_select_out_1_n, chip_select_out_0_n};
  always #12.5 clk = ~clk;
  cs_wait_bus i_dut (.clk, .rstn, .cfg_we, .cfg_sel, .cfg_control, .cfg_lower_bound, .cfg_upper_bound,
    .cfg_bus_mode, .cfg_state_len, .cfg_mux_enable, .rd_control, .rd_lower_bound, .rd_upper_bound,
    .cpu_req, .cpu_is_io, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_ready, .cpu_rdata, .addr_out,
    .data_out, .data_oe, .data_in, .chip_select_out_0_n, .chip_select_out_1_n, .chip_select_out_2_n,
    .chip_select_out_3_n, .memory_request_n, .io_request_n, .rd_n, .wr_n, .addr_latch(), .wait_n,
    .bus_request_in_n, .bus_grant_out_n, .ext_addr, .ext_memory_request_n, .ext_io_request_n);
  ext_bus_model i_mem (.clk, .rstn, .addr_out, .rd_n, .sel_n(cs_n), .stall_len, .data_in, .wait_n);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic step;
    @(posedge clk);
    #2;
  endtask : step
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] ctl(input logic [2:0] w, input logic io);
    return {w, io, 1'b1, 3'h0};
  endfunction : ctl
  task automatic cfg(input logic [1:0] s, input logic [7:0] c, lb, ub, input logic [1:0] m, input logic [3:0] l);
    cfg_sel = s;
    cfg_control = c;
    cfg_lower_bound = lb;
    cfg_upper_bound = ub;
    cfg_bus_mode = m;
    cfg_state_len = l;
    cfg_we = 1;
    step();
    cfg_we = 0;
    step();
  endtask : cfg
  // cs below zero: the request must never be taken
  task automatic access(input logic io, wr, input logic [23:0] a, input int cs, output int n);
    logic [3:0] seen;
    logic [3:0] st;
    logic       dbad;
    seen = 0;
    st = 0;
    dbad = 0;
    n = 0;
    cpu_is_io = io;
    cpu_wr = wr;
    cpu_addr = a;
    cpu_wdata = ~a[7:0];
    cpu_req = 1;
    do begin
      step();
      n++;
      if (seen == 0 && !(&cs_n)) fc = n;
      if (st[1] == 0 && !rd_n) fr = n;
      seen = seen | ~cs_n;
      st = st | ~{memory_request_n, io_request_n, rd_n, wr_n};
      if (!(&cs_n) && addr_out !== a) dbad = 1;
      if (!wr_n && !(data_oe === 1'b1 && data_out === ~a[7:0])) dbad = 1;
    end while (cpu_ready !== 1'b1 && n < 60);
    cpu_req = 0;
    if (cs < 0) begin
      chk("not taken", 0, {seen, cpu_ready});
    end else begin
      chk("select", 1 << cs, seen);
      chk("strobes", {!io, io, !wr, wr}, st);
      chk("ready", 1, cpu_ready);
      chk("bus pins", 0, dbad);
      if (!wr) chk("read data", a[7:0] ^ 8'h5a, cpu_rdata);
    end
    step();
  endtask : access
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    step();
    step();
    chk("bounds 0", 16'h00ff, {rd_lower_bound, rd_upper_bound});
    chk("control 0", 0, rd_control);
    cfg_sel = 1;
    step();
    step();
    chk("bounds 1", 0, {rd_lower_bound, rd_upper_bound});
    access(0, 0, 24'h123456, -1, lat);
  endtask : t_reset
  task automatic t_mem;
    cfg(0, ctl(0, 0), 8'h00, 8'h7f, MODE_NATIVE, 1);
    cfg(1, ctl(0, 0), 8'h00, 8'h9f, MODE_NATIVE, 1);
    cfg(2, ctl(0, 0), 8'ha0, 8'ha0, MODE_NATIVE, 1);
    cfg(3, ctl(0, 0), 8'hd0, 8'hff, MODE_NATIVE, 1);
    chk("readback 3", {ctl(0, 0), 16'hd0ff}, {rd_control, rd_lower_bound, rd_upper_bound});
    access(0, 0, 24'h7fffff, 0, lat);
    access(0, 1, 24'h800000, 1, lat);
    access(0, 0, 24'ha0ffff, 2, lat);
    access(0, 1, 24'hc00000, -1, lat);
    access(0, 0, 24'hd00001, 3, lat);
    access(1, 0, 24'h007000, -1, lat);
  endtask : t_mem
  task automatic t_io;
    cfg(3, ctl(0, 1), 8'h12, 8'h00, MODE_NATIVE, 1);
    cfg(2, ctl(0, 1), 8'h00, 8'h00, MODE_NATIVE, 1);
    access(1, 0, 24'hff1234, 3, lat);
    access(1, 1, 24'h001299, 3, lat);
    access(0, 0, 24'hff1234, -1, lat);
    access(1, 0, 24'h00007f, 2, lat);
    access(1, 0, 24'h000080, -1, lat);
    access(1, 1, 24'h0000ff, -1, lat);
    cfg(2, 8'h10, 8'h00, 8'h00, MODE_NATIVE, 1);
    access(1, 0, 24'h000050, -1, lat);
  endtask : t_io
  task automatic t_wait;
    for (int w = 0; w < 8; w++) begin
      cfg(1, ctl(3'(w), 0), 8'h00, 8'h9f, MODE_NATIVE, 1);
      access(0, 0, 24'h800000, 1, lat);
      chk("wait latency", w + 2, lat);
    end
    // the wait pin passes a synchroniser, so the stalling select uses all seven wait states
    cfg(1, ctl(7, 0), 8'h00, 8'h9f, MODE_NATIVE, 1);
    access(0, 0, 24'h800000, 1, base);
    stall_len = 6;
    access(0, 0, 24'h800000, 1, lat);
    stall_len = 0;
    chk("stall", 1, lat >= base + 3 && lat <= base + 10);
  endtask : t_wait
  task automatic t_legacy;
    int lens[3] = '{1, 2, 15};
    foreach (lens[i]) begin
      cfg(0, ctl(0, 0), 8'h00, 8'h7f, MODE_LEGACY, 4'(lens[i]));
      access(0, 0, 24'h001234, 0, lat);
      chk("legacy length", 3 * lens[i] + 1, lat);
      chk("strobe state", lens[i], fr - fc);
    end
    access(0, 0, 24'h800000, 1, lat);
    chk("native beside legacy", 9, lat);
    cfg(0, ctl(0, 0), 8'h00, 8'h7f, MODE_LEGACY, 4);
    stall_len = 5;
    access(0, 0, 24'h001234, 0, lat);
    stall_len = 0;
    chk("legacy wait", 1, lat >= 14 && lat <= 21);
    cfg(0, ctl(0, 0), 8'h00, 8'h7f, MODE_NATIVE, 1);
  endtask : t_legacy
  task automatic t_grant;
    bus_request_in_n = 0;
    for (int k = 0; k < 20 && bus_grant_out_n !== 1'b0; k++) step();
    chk("grant", 0, bus_grant_out_n);
    ext_addr = 24'h400000;
    ext_memory_request_n = 0;
    cpu_addr = 24'h400000;
    cpu_req = 1;
    step();
    chk("external decode", 4'he, cs_n);
    repeat (5) step();
    chk("no answer", 0, cpu_ready);
    cpu_req = 0;
    ext_memory_request_n = 1;
    bus_request_in_n = 1;
    for (int k = 0; k < 20 && bus_grant_out_n !== 1'b1; k++) step();
    chk("release", 5'h1f, {bus_grant_out_n, cs_n});
  endtask : t_grant
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge clk);
    #2;
    rstn = 1;
    t_reset();
    t_mem();
    t_io();
    t_wait();
    t_legacy();
    t_grant();
    complete_run();
  end
  initial begin
    repeat (WD_CYCLES) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
